// ===== adc_ctrl_pkg.sv
/*
 Package for the converter control block: register map, field positions,
 reset values, trigger and format codes, bus response codes, sequencer states.
 Assumes a 100 MHz clock and an AXI4-Lite master on the register side.
*/
// Operation
// [R01] Converter runs only while the module enable bit is one.
// [R02] Halt-in-idle set stops conversion while the processor idles.
// [R03] Bits 31:16, 14, 12, 11 and 3 read zero, ignore writes.
// [R04] Integer formats right-justify; 000/100 zero-fill, 101 sign-extends to 32.
// [R05] Fractional formats left-justify at 15:6 or 31:22; signed keeps sign on top.
// [R06] Trigger 111: internal counter ends sampling, starts conversion.
// [R07] Trigger 011: charge-time unit signal ends sampling.
// [R08] Trigger 010: third timer period match ends sampling.
// [R09] Trigger 001: external interrupt zero edge ends sampling.
// [R10] Trigger 000: software clearing sample-active ends sampling.
// [R11] Software sets sample-active, or hardware does with auto-sample on.
// [R12] Nonzero trigger: hardware clears sample-active to start conversion.
// [R13] Done flag set when a conversion completes.
// [R14] Software clears done with zero only; clear leaves conversion running.
// [R15] Done flag cleared when a new conversion starts.
// [R16] Software avoids register access the cycle after disabling module.
// [R17] Trigger codes 100, 101, 110 have no trigger behaviour.
// [R18] Format 001 sign-extends the result to 16 bits.
// [R19] One-shot bit clears auto-sample after next conversion completes.
// [R20] Idle halts only the processor; block continues unless halt-in-idle.

package adc_ctrl_pkg;

    // ==========================================================
    // Register map
    localparam logic [3:0]  CTRL_ONE_OFFS   = 4'h0;
    localparam logic [3:0]  RESULT_OFFS     = 4'h4;
    localparam logic [3:0]  SAMPLE_TIME_OFFS = 4'h8;
    localparam logic [31:0] CTRL_ONE_RESET  = 32'h0000_0000;
    localparam logic [31:0] CTRL_ONE_WMASK  = 32'h0000_A7F6;
    localparam logic [31:0] CTRL_ONE_RMASK  = 32'h0000_A7F7;
    localparam logic [7:0]  SAMPLE_TIME_RESET = 8'h10;

    // ==========================================================
    // Field positions
    localparam int ENABLE_BIT   = 15;
    localparam int IDLE_BIT     = 13;
    localparam int FORMAT_LSB   = 8;
    localparam int TRIGGER_LSB  = 5;
    localparam int ONE_SHOT_BIT = 4;
    localparam int AUTO_BIT     = 2;
    localparam int SAMPLE_BIT   = 1;
    localparam int DONE_BIT     = 0;

    // ==========================================================
    // Codes
    localparam logic [2:0] TRIG_SOFT  = 3'h0;
    localparam logic [2:0] TRIG_IRQ0  = 3'h1;
    localparam logic [2:0] TRIG_TMR3  = 3'h2;
    localparam logic [2:0] TRIG_CTU   = 3'h3;
    localparam logic [2:0] TRIG_AUTO  = 3'h7;

    localparam logic [2:0] FMT_INT16   = 3'h0;
    localparam logic [2:0] FMT_SINT16  = 3'h1;
    localparam logic [2:0] FMT_FRAC16  = 3'h2;
    localparam logic [2:0] FMT_SFRAC16 = 3'h3;
    localparam logic [2:0] FMT_INT32   = 3'h4;
    localparam logic [2:0] FMT_SINT32  = 3'h5;
    localparam logic [2:0] FMT_FRAC32  = 3'h6;
    localparam logic [2:0] FMT_SFRAC32 = 3'h7;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SAMPLE  = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_t;

endpackage : adc_ctrl_pkg

// ===== result_store.sv
/*
 Result holding register: formats a raw 10-bit result into the output word.
 Assumes the raw result is valid in the cycle its strobe is high.
*/
`timescale 1ns/1ps
`default_nettype none

module result_store
    import adc_ctrl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        load,
    input  wire logic [2:0]  format,
    input  wire logic [9:0]  raw,
    output logic      [31:0] word
);

    logic [31:0] word_q;
    logic [31:0] word_d;

    // ==========================================================
    // Formatting
    function automatic logic [31:0] shape(input logic [2:0] f, input logic [9:0] r);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (f)
            // [R04] integer justify
            FMT_INT16, FMT_INT32: w = {22'h0, r};
            FMT_SINT32:           w = {{22{r[9]}}, r};
            // [R18] signed 16-bit integer
            FMT_SINT16:           w = {16'h0, {6{r[9]}}, r};
            // [R05] fractional justify
            FMT_FRAC16, FMT_SFRAC16: w = {16'h0, r, 6'h0};
            FMT_FRAC32, FMT_SFRAC32: w = {r, 22'h0};
        endcase
        return w;
    endfunction : shape

    always_comb begin
        word_d = load ? shape(format, raw) : word_q;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            word_q <= 32'h0000_0000;
        end else begin
            word_q <= word_d;
        end
    end

    assign word = word_q;

endmodule : result_store

`default_nettype wire

// ===== adc_sample_convert_control.sv
/*
 Converter control top: AXI4-Lite slave holding the first control register,
 sample/convert sequencer and trigger selection, result word register.
 Assumes trigger inputs and the analog core signals are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module adc_sample_convert_control
    import adc_ctrl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    // AXI4-Lite
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // System and trigger sources
    input  wire logic        cpuIdle,
    input  wire logic        externalIrqZero,
    input  wire logic        timerThreeMatch,
    input  wire logic        chargeTimeUnitTrig,
    // Analog core
    output logic             sampleHold,
    output logic             convertStart,
    input  wire logic        convertDone,
    input  wire logic [9:0]  convertResult
);

    // ==========================================================
    // State
    logic [31:0] ctrl_q, ctrl_d;
    logic [7:0]  sampTime_q, sampTime_d;
    logic [7:0]  sampCnt_q, sampCnt_d;
    conv_state_t state_q, state_d;
    logic        irqPrev_q, irqPrev_d;
    logic        start_q, start_d;
    logic        hold_q, hold_d;

    logic        awHeld_q, awHeld_d, wHeld_q, wHeld_d, bvalid_q, bvalid_d;
    logic [3:0]  awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d;
    logic [3:0]  wStrb_q, wStrb_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;

    logic [31:0] resultWord;

    // ==========================================================
    // Bus helpers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    wire logic doWrite = awHeld_q && wHeld_q && !bvalid_q;
    wire logic doRead  = s_axi_arvalid && !rvalid_q;
    wire logic ctrlWr  = doWrite && (awAddr_q == CTRL_ONE_OFFS);
    wire logic [31:0] ctrlWv = merge(ctrl_q, wData_q, wStrb_q);

    wire logic enabled = ctrl_q[ENABLE_BIT];
    // [R02] idle halt
    wire logic halted  = ctrl_q[IDLE_BIT] && cpuIdle;
    wire logic running = enabled && !halted;
    wire logic [2:0] trig = ctrl_q[TRIGGER_LSB +: 3];

    // Trigger event select
    logic trigHit;
    always_comb begin
        trigHit = 1'b0;
        unique case (trig)
            // [R06] internal counter
            TRIG_AUTO: trigHit = (sampCnt_q == 8'h00);
            // [R07] charge-time unit
            TRIG_CTU:  trigHit = chargeTimeUnitTrig;
            // [R08] timer three match
            TRIG_TMR3: trigHit = timerThreeMatch;
            // [R09] irq zero edge
            TRIG_IRQ0: trigHit = externalIrqZero && !irqPrev_q;
            // [R17] reserved codes inert
            default:   trigHit = 1'b0;
        endcase
    end

    // ==========================================================
    // Bus channels
    always_comb begin
        awHeld_d = awHeld_q;
        awAddr_d = awAddr_q;
        wHeld_d  = wHeld_q;
        wData_d  = wData_q;
        wStrb_d  = wStrb_q;
        bvalid_d = bvalid_q;
        bresp_d  = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (s_axi_awvalid && !awHeld_q) begin
            awHeld_d = 1'b1;
            awAddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wHeld_q) begin
            wHeld_d = 1'b1;
            wData_d = s_axi_wdata;
            wStrb_d = s_axi_wstrb;
        end
        if (doWrite) begin
            awHeld_d = 1'b0;
            wHeld_d  = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = (awAddr_q == CTRL_ONE_OFFS || awAddr_q == SAMPLE_TIME_OFFS ||
                        awAddr_q == RESULT_OFFS) ? RESP_OKAY : RESP_SLVERR;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (doRead) begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            unique case (s_axi_araddr)
                // [R03] reserved bits read zero
                CTRL_ONE_OFFS:    rdata_d = ctrl_q & CTRL_ONE_RMASK;
                RESULT_OFFS:      rdata_d = resultWord;
                SAMPLE_TIME_OFFS: rdata_d = {24'h0, sampTime_q};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // ==========================================================
    // Control register and sequencer
    always_comb begin
        ctrl_d     = ctrl_q;
        sampTime_d = sampTime_q;
        sampCnt_d  = sampCnt_q;
        state_d    = state_q;
        irqPrev_d  = externalIrqZero;
        start_d    = 1'b0;
        hold_d     = 1'b0;

        if (ctrlWr) begin
            // [R03] reserved writes ignored
            ctrl_d = (ctrl_q & ~CTRL_ONE_WMASK) | (ctrlWv & CTRL_ONE_WMASK);
            // [R14] done cleared by zero only
            ctrl_d[DONE_BIT] = ctrl_q[DONE_BIT] & ctrlWv[DONE_BIT];
        end
        if (doWrite && awAddr_q == SAMPLE_TIME_OFFS && wStrb_q[0]) begin
            sampTime_d = wData_q[7:0];
        end

        // [R01] disabled module idles
        if (!enabled) begin
            state_d = ST_IDLE;
            ctrl_d[SAMPLE_BIT] = ctrlWr ? ctrlWv[SAMPLE_BIT] : ctrl_q[SAMPLE_BIT];
        // [R20] runs through idle unless halted
        end else if (running) begin
            unique case (state_q)
                ST_IDLE: begin
                    // [R11] auto-sample sets sample bit
                    if (ctrl_q[AUTO_BIT]) begin
                        ctrl_d[SAMPLE_BIT] = 1'b1;
                    end
                    if (ctrl_d[SAMPLE_BIT]) begin
                        state_d   = ST_SAMPLE;
                        sampCnt_d = sampTime_q;
                    end
                end
                ST_SAMPLE: begin
                    hold_d = 1'b1;
                    if (sampCnt_q != 8'h00) begin
                        sampCnt_d = sampCnt_q - 8'h01;
                    end
                    if (trig == TRIG_SOFT) begin
                        // [R10] software clear starts conversion
                        if (!ctrl_d[SAMPLE_BIT]) begin
                            state_d = ST_CONVERT;
                            start_d = 1'b1;
                        end
                    end else if (trigHit) begin
                        // [R12] hardware clears sample bit
                        ctrl_d[SAMPLE_BIT] = 1'b0;
                        state_d = ST_CONVERT;
                        start_d = 1'b1;
                    end
                    if (start_d) begin
                        // [R15] done cleared at start
                        ctrl_d[DONE_BIT] = 1'b0;
                        hold_d = 1'b0;
                    end
                end
                ST_CONVERT: begin
                    if (convertDone) begin
                        // [R13] done set, wins over clear
                        ctrl_d[DONE_BIT] = 1'b1;
                        state_d = ST_IDLE;
                        // [R19] one-shot auto-sample
                        if (ctrl_q[ONE_SHOT_BIT]) begin
                            ctrl_d[AUTO_BIT] = 1'b0;
                        end
                    end
                end
                default: state_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q     <= CTRL_ONE_RESET;
            sampTime_q <= SAMPLE_TIME_RESET;
            sampCnt_q  <= 8'h00;
            state_q    <= ST_IDLE;
            irqPrev_q  <= 1'b0;
            start_q    <= 1'b0;
            hold_q     <= 1'b0;
            awHeld_q   <= 1'b0;
            awAddr_q   <= 4'h0;
            wHeld_q    <= 1'b0;
            wData_q    <= 32'h0000_0000;
            wStrb_q    <= 4'h0;
            bvalid_q   <= 1'b0;
            bresp_q    <= RESP_OKAY;
            rvalid_q   <= 1'b0;
            rdata_q    <= 32'h0000_0000;
            rresp_q    <= RESP_OKAY;
        end else begin
            ctrl_q     <= ctrl_d;
            sampTime_q <= sampTime_d;
            sampCnt_q  <= sampCnt_d;
            state_q    <= state_d;
            irqPrev_q  <= irqPrev_d;
            start_q    <= start_d;
            hold_q     <= hold_d;
            awHeld_q   <= awHeld_d;
            awAddr_q   <= awAddr_d;
            wHeld_q    <= wHeld_d;
            wData_q    <= wData_d;
            wStrb_q    <= wStrb_d;
            bvalid_q   <= bvalid_d;
            bresp_q    <= bresp_d;
            rvalid_q   <= rvalid_d;
            rdata_q    <= rdata_d;
            rresp_q    <= rresp_d;
        end
    end

    // Result formatted at capture time, so a later format change needs a new conversion
    result_store u_result (
        .clk    (clk),
        .rstn   (rstn),
        .load   (state_q == ST_CONVERT && convertDone && running),
        .format (ctrl_q[FORMAT_LSB +: 3]),
        .raw    (convertResult),
        .word   (resultWord)
    );

    assign s_axi_awready = !awHeld_q;
    assign s_axi_wready  = !wHeld_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign sampleHold    = hold_q;
    assign convertStart  = start_q;

endmodule : adc_sample_convert_control

`default_nettype wire

// ===== adc_ctrl_sva.sv
/*
 Checker for the converter control top ports.
 Assumes a bind onto adc_sample_convert_control.
*/
`timescale 1ns/1ps
`default_nettype none

module adc_ctrl_sva
    import adc_ctrl_pkg::*;
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [3:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        sampleHold,
    input wire logic        convertStart
);
    // ==========
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_start_one_pulse: assert property (convertStart |=> !convertStart)
        else $error("conversion start longer than one cycle");
    a_start_ends_sample: assert property ($rose(convertStart) |-> $past(sampleHold) && !sampleHold)
        else $error("conversion started without a sample phase");
    a_ctrl_reserved_zero: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == CTRL_ONE_OFFS
        |=> (s_axi_rdata & 32'hFFFF_5808) == 32'h0)
        else $error("unused control bits read nonzero");
    a_unmapped_error: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hC
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not released");
    a_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not released");
endmodule : adc_ctrl_sva

bind adc_sample_convert_control adc_ctrl_sva adc_ctrl_sva_inst (.clk, .rstn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sampleHold, .convertStart);

`default_nettype wire

// ===== adc_core_model.sv
/*
 Behavioural analog conversion core.
 Assumes convertStart is a one-cycle pulse; delay is at least one cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module adc_core_model (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        convertStart,
    input wire logic [7:0]  delay,
    input wire logic [9:0]  value,
    output var logic        convertDone,
    output var logic [9:0]  convertResult
);
    logic [7:0] count_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_q <= 8'h0;
            convertDone <= 1'b0;
            convertResult <= 10'h0;
        end else begin
            count_q <= convertStart ? delay : (count_q != 8'h0 ? count_q - 8'h1 : 8'h0);
            convertDone <= count_q == 8'h1;
            // Outside the done cycle the result toggles, so a late capture is seen
            convertResult <= count_q == 8'h1 ? value : ~convertResult;
        end
    end
endmodule : adc_core_model

`default_nettype wire

// ===== adc_sample_convert_control_tb_top.sv
/*
 Testbench: AXI4-Lite register tasks driving the converter control.
 Assumes the core model answers after coreDelay cycles.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin totalChecks++; if ((g) !== (e)) begin nMismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module adc_sample_convert_control_tb_top;
    import adc_ctrl_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdVal;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rdResp;
    logic        cpuIdle = 1'b0, externalIrqZero = 1'b0, timerThreeMatch = 1'b0, chargeTimeUnitTrig = 1'b0;
    logic        sampleHold, convertStart, convertDone;
    logic [9:0]  convertResult, coreValue = 10'h2A5;
    logic [7:0]  coreDelay = 8'h14;
    int          nMismatch = 0, totalChecks = 0;

    always #5 clk = ~clk;

    adc_sample_convert_control adc_sample_convert_control_inst (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .cpuIdle, .externalIrqZero, .timerThreeMatch, .chargeTimeUnitTrig, .sampleHold,
        .convertStart, .convertDone, .convertResult);
    adc_core_model adc_core_model_inst (.clk, .rstn, .convertStart, .delay(coreDelay), .value(coreValue),
        .convertDone, .convertResult);

    // ==========
    // Bus tasks
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        if (s_axi_bvalid !== 1'b1) nMismatch++;
        s_axi_bready <= 1'b0;
        `CHK("bresp", RESP_OKAY, s_axi_bresp)
    endtask : wr

    task automatic rd(input logic [3:0] a);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        if (s_axi_rvalid !== 1'b1) nMismatch++;
        rdVal = s_axi_rdata;
        rdResp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string nm);
        rd(a);
        `CHK(nm, e, rdVal)
    endtask : rdc

    task automatic waitDone();
        int n;
        n = 0;
        do begin
            rd(CTRL_ONE_OFFS);
            n++;
        end while (rdVal[DONE_BIT] !== 1'b1 && n < 200);
        if (rdVal[DONE_BIT] !== 1'b1) nMismatch++;
    endtask : waitDone

    function automatic logic [31:0] fmtExp(input logic [2:0] f, input logic [9:0] r);
        case (f)
            3'h1: return {16'h0, {6{r[9]}}, r};
            3'h5: return {{22{r[9]}}, r};
            3'h2, 3'h3: return {16'h0, r, 6'h0};
            3'h6, 3'h7: return {r, 22'h0};
            default: return {22'h0, r};
        endcase
    endfunction : fmtExp

    task automatic results();
        if (nMismatch == 0 && totalChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // ==========
    // Tests
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rdc(CTRL_ONE_OFFS, CTRL_ONE_RESET, "ctrl reset");
        rdc(SAMPLE_TIME_OFFS, {24'h0, SAMPLE_TIME_RESET}, "sample time reset");
        // done only ever written as zero
        wr(CTRL_ONE_OFFS, 32'hFFFF_7FFE);
        repeat (40) @(posedge clk);
        rdc(CTRL_ONE_OFFS, 32'h0000_27F6, "ctrl masked idle");
        `CHK("hold while off", 1'b0, sampleHold)
        rd(4'hC);
        `CHK("unmapped resp", RESP_SLVERR, rdResp)
        wr(RESULT_OFFS, 32'hFFFF_FFFF);
        rdc(RESULT_OFFS, 32'h0, "result read only");
        for (int f = 0; f < 8; f++) begin
            wr(CTRL_ONE_OFFS, 32'h8002 | 32'(f << 8));
            wr(CTRL_ONE_OFFS, 32'h8000 | 32'(f << 8));
            rd(CTRL_ONE_OFFS);
            `CHK("done at start", 1'b0, rdVal[DONE_BIT])
            // Clearing done mid-conversion must not stop it
            wr(CTRL_ONE_OFFS, 32'h8000 | 32'(f << 8));
            waitDone();
            rdc(RESULT_OFFS, fmtExp(3'(f), coreValue), "result word");
        end
        wr(CTRL_ONE_OFFS, 32'h8000);
        rdc(CTRL_ONE_OFFS, 32'h8000, "done cleared");
        // Idle without halt must not stop the triggers
        cpuIdle <= 1'b1;
        coreDelay <= 8'h1;
        for (int t = 1; t < 8; t++) begin
            wr(CTRL_ONE_OFFS, 32'h8002 | 32'(t << 5));
            repeat (4) @(posedge clk);
            externalIrqZero <= t == 1 || t inside {[4:6]};
            timerThreeMatch <= t == 2 || t inside {[4:6]};
            chargeTimeUnitTrig <= t == 3 || t inside {[4:6]};
            @(posedge clk);
            externalIrqZero <= 1'b0;
            timerThreeMatch <= 1'b0;
            chargeTimeUnitTrig <= 1'b0;
            if (t inside {[4:6]}) begin
                repeat (40) @(posedge clk);
                rdc(CTRL_ONE_OFFS, 32'h8002 | 32'(t << 5), "reserved trigger");
            end else begin
                waitDone();
                rdc(CTRL_ONE_OFFS, 32'h8001 | 32'(t << 5), "trigger");
            end
        end
        wr(CTRL_ONE_OFFS, 32'hA0E2);
        repeat (60) @(posedge clk);
        rdc(CTRL_ONE_OFFS, 32'hA0E2, "halted in idle");
        cpuIdle <= 1'b0;
        waitDone();
        rdc(CTRL_ONE_OFFS, 32'hA0E1, "resumed after idle");
        coreDelay <= 8'h40;
        wr(CTRL_ONE_OFFS, 32'h80F4);
        waitDone();
        rd(CTRL_ONE_OFFS);
        `CHK("auto one shot", 1'b0, rdVal[AUTO_BIT])
        // Done left standing by one conversion must drop when hardware starts the next
        wr(CTRL_ONE_OFFS, 32'h8024);
        repeat (4) @(posedge clk);
        externalIrqZero <= 1'b1;
        @(posedge clk);
        externalIrqZero <= 1'b0;
        waitDone();
        repeat (4) @(posedge clk);
        externalIrqZero <= 1'b1;
        @(posedge clk);
        externalIrqZero <= 1'b0;
        repeat (4) @(posedge clk);
        rd(CTRL_ONE_OFFS);
        `CHK("done cleared at start", 1'b0, rdVal[DONE_BIT])
        wr(CTRL_ONE_OFFS, 32'h80E2);
        wr(CTRL_ONE_OFFS, 32'h00E2);
        repeat (2) @(posedge clk);
        `CHK("hold after disable", 1'b0, sampleHold)
        results();
    end

    initial begin
        repeat (50000) @(posedge clk);
        nMismatch++;
        results();
    end
endmodule : adc_sample_convert_control_tb_top

`default_nettype wire
